// ### rtl/conv_ctrl_pkg.sv
`default_nettype none
package conv_ctrl_pkg;
	// Register map
	localparam int          ADDR_WIDTH     = 12;
	localparam logic [11:0] CTRL_OFFSET    = 12'h008;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	// Field positions inside the control word
	localparam int          POWER_BIT      = 0;
	localparam int          REPEAT_BIT     = 1;
	localparam int          CAL_BIT        = 2;
	localparam int          TRIM_BIT       = 3;
	localparam int          DMA_BIT        = 8;
	// Bits that hold storage; everything else reads as zero
	localparam logic [31:0] STORED_MASK    = 32'h0000_010F;
	// Stored bits other than the enable, used for the changed-bits check
	localparam logic [31:0] OTHER_MASK     = 32'h0000_010E;
	// Converter instance that never raises transfer requests
	localparam int          NO_REQ_INSTANCE = 2;
	// Synchroniser depth for inputs from the analog side
	localparam int          SYNC_STAGES    = 3;
endpackage
`default_nettype wire

// ### rtl/event_sync.sv
`default_nettype none
module event_sync
	import conv_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Toggle from the analog domain
	input  wire logic toggle_in,
	// One-cycle pulse per accepted toggle change
	output logic      event_pulse
);
	logic [SYNC_STAGES-1:0] stages;
	logic                   stable;
	logic                   next_stable;
	logic                   next_pulse;

	// A change counts once the second and third stages agree
	always_comb
	begin
		next_stable = stable;
		next_pulse  = 1'b0;
		if (stages[1] == stages[2] && stages[2] != stable)
		begin
			next_stable = stages[2];
			next_pulse  = 1'b1;
		end
	end

	// Shift chain and edge state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stages      <= '0;
			stable      <= 1'b0;
			event_pulse <= 1'b0;
		end
		else
		begin
			stages      <= {stages[SYNC_STAGES-2:0], toggle_in};
			stable      <= next_stable;
			event_pulse <= next_pulse;
		end
	end
endmodule
`default_nettype wire

// ### rtl/converter_control_second.sv
`default_nettype none
// Contract
// RULE1: Register at 0x08, resets to all zero
// RULE2: Enable write from 0 powers up, starts
// RULE3: Enable write while on restarts conversion only
// RULE4: Enable write 0 stops everything, powers down
// RULE5: No start when other bits change too
// RULE6: Bit 1 picks single or continuous conversion
// RULE7: Calibration bit self-clears when calibration finishes
// RULE8: Trim clear bit self-clears when done
// RULE9: Second instance never raises transfer requests
// RULE10: One request per conversion while enabled
module converter_control_second
	import conv_ctrl_pkg::*;
#(
	parameter int INSTANCE = 1
)
(
	// Clock and reset
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [conv_ctrl_pkg::ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Toggles from the analog core
	input  wire logic                              conv_done_toggle,
	input  wire logic                              cal_done_toggle,
	input  wire logic                              trim_done_toggle,
	// Controls to the analog core
	output logic                                   converter_power_start,
	output logic                                   repeat_conversion_select,
	output logic                                   calibration_run,
	output logic                                   trim_store_clear,
	output logic                                   conversion_start,
	// Request to the transfer controller
	output logic                                   transfer_request
);
	logic        transfer_request_enable;
	logic        conv_done;
	logic        cal_done;
	logic        trim_done;
	logic        access_fire;
	logic        write_fire;
	logic        ctrl_hit;
	logic        others_changed;
	logic [31:0] ctrl_word;
	logic        next_power;
	logic        next_repeat;
	logic        next_cal;
	logic        next_trim;
	logic        next_dma_en;
	logic        next_start;
	logic        next_request;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	// Analog side events enter through three-stage synchronisers
	event_sync u_conv_sync
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.toggle_in   (conv_done_toggle),
		.event_pulse (conv_done)
	);
	event_sync u_cal_sync
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.toggle_in   (cal_done_toggle),
		.event_pulse (cal_done)
	);
	event_sync u_trim_sync
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.toggle_in   (trim_done_toggle),
		.event_pulse (trim_done)
	);

	// Bus decode and current register image
	assign ctrl_hit    = (paddr == CTRL_OFFSET);
	assign access_fire = psel & penable & pready;
	assign write_fire  = access_fire & pwrite & ctrl_hit;
	always_comb
	begin
		ctrl_word           = CTRL_RESET;
		ctrl_word[POWER_BIT]  = converter_power_start;
		ctrl_word[REPEAT_BIT] = repeat_conversion_select;
		ctrl_word[CAL_BIT]    = calibration_run;
		ctrl_word[TRIM_BIT]   = trim_store_clear;
		ctrl_word[DMA_BIT]    = transfer_request_enable;
	end
	assign others_changed = ((pwdata & OTHER_MASK) != (ctrl_word & OTHER_MASK));

	// APB answer: ready one cycle after setup, data captured in setup
	always_comb
	begin
		next_pready  = psel & ~penable;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (psel && !penable)
		begin
			next_prdata  = ctrl_hit && !pwrite ? (ctrl_word & STORED_MASK) : 32'h0000_0000; // RULE1
			next_pslverr = ~ctrl_hit;
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Control fields, conversion start and transfer request
	always_comb
	begin
		next_power   = converter_power_start;
		next_repeat  = repeat_conversion_select;
		next_cal     = calibration_run;
		next_trim    = trim_store_clear;
		next_dma_en  = transfer_request_enable;
		next_start   = 1'b0;
		next_request = 1'b0;
		// Hardware completion clears; a set in the same cycle wins below unless the write powers down
		if (cal_done)
		begin
			next_cal = 1'b0; // RULE7
		end
		if (trim_done)
		begin
			next_trim = 1'b0; // RULE8
		end
		// Continuous mode reissues a start after every conversion
		if (conv_done && converter_power_start && repeat_conversion_select)
		begin
			next_start = 1'b1; // RULE6
		end
		// One request per finished conversion, never on instance two
		if (conv_done && transfer_request_enable && INSTANCE != NO_REQ_INSTANCE)
		begin
			next_request = 1'b1; // RULE9 RULE10
		end
		if (write_fire)
		begin
			next_repeat = pwdata[REPEAT_BIT];
			next_dma_en = pwdata[DMA_BIT];
			if (pwdata[CAL_BIT])
			begin
				next_cal = 1'b1; // RULE7
			end
			if (pwdata[TRIM_BIT])
			begin
				next_trim = 1'b1; // RULE8
			end
			if (!pwdata[POWER_BIT])
			begin
				// Power down aborts conversion and calibration work
				next_power = 1'b0; // RULE4
				next_cal   = 1'b0; // RULE4
				next_trim  = 1'b0; // RULE4
				next_start = 1'b0; // RULE4
			end
			else if (others_changed)
			begin
				// Mixed write: enable follows but no conversion is started
				next_power = 1'b1;
				next_start = 1'b0; // RULE5
			end
			else
			begin
				// From off this powers up; from on it only restarts
				next_power = 1'b1; // RULE2 RULE3
				next_start = 1'b1; // RULE2 RULE3
			end
		end
	end

	// Control registers, all zero after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			converter_power_start    <= 1'b0; // RULE1
			repeat_conversion_select <= 1'b0;
			calibration_run          <= 1'b0;
			trim_store_clear         <= 1'b0;
			transfer_request_enable  <= 1'b0;
			conversion_start         <= 1'b0;
			transfer_request         <= 1'b0;
		end
		else
		begin
			converter_power_start    <= next_power;
			repeat_conversion_select <= next_repeat;
			calibration_run          <= next_cal;
			trim_store_clear         <= next_trim;
			transfer_request_enable  <= next_dma_en;
			conversion_start         <= next_start;
			transfer_request         <= next_request;
		end
	end

	// Reserved bits of a register read are zero
	chk_read_reserved: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		(psel && penable && pready && ctrl_hit) |-> ((prdata & ~STORED_MASK) == 32'h0000_0000))
		else $error("reserved control bits read nonzero");

	// Enable from off powers up and starts one conversion
	chk_power_up_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		(write_fire && pwdata[POWER_BIT] && !converter_power_start && !others_changed)
		|=> (converter_power_start && conversion_start)
		##1 (!conversion_start || $past(conv_done && repeat_conversion_select)))
		else $error("enable from off did not power up and start");

	// Enable while on restarts without touching power
	chk_restart_on: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		(write_fire && pwdata[POWER_BIT] && converter_power_start && !others_changed)
		|=> (conversion_start && $stable(converter_power_start)))
		else $error("enable while on did not restart");

	// Writing zero to enable powers down and aborts calibration
	chk_power_down: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		(write_fire && !pwdata[POWER_BIT])
		|=> (!converter_power_start && !calibration_run && !trim_store_clear && !conversion_start))
		else $error("power down write left activity running");

	// A write that changes other bits never starts a conversion
	chk_mixed_no_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		(write_fire && pwdata[POWER_BIT] && others_changed && !conv_done) |=> !conversion_start)
		else $error("mixed write triggered a conversion");

	// Continuous mode restarts after each finished conversion
	chk_continuous: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		(conv_done && converter_power_start && repeat_conversion_select && !write_fire)
		|=> conversion_start)
		else $error("continuous mode failed to restart");

	// Single mode never restarts by itself
	chk_single_mode: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		(!write_fire && !repeat_conversion_select) |=> !conversion_start)
		else $error("single mode restarted on its own");

	// Calibration bit drops when calibration finishes
	chk_cal_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		(cal_done && !write_fire) |=> !calibration_run)
		else $error("calibration bit stayed set after completion");

	// Trim clear bit drops when the clear finishes
	chk_trim_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		(trim_done && !write_fire) |=> !trim_store_clear)
		else $error("trim clear bit stayed set after completion");

	// A software set of calibration beats a same-cycle completion
	chk_cal_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		(write_fire && pwdata[POWER_BIT] && pwdata[CAL_BIT]) |=> calibration_run)
		else $error("calibration set lost against completion");

	// A software set of the trim clear beats a same-cycle completion
	chk_trim_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		(write_fire && pwdata[POWER_BIT] && pwdata[TRIM_BIT]) |=> trim_store_clear)
		else $error("trim clear set lost against completion");

	// Instance two keeps its request line low at all times
	chk_no_req_inst: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		(INSTANCE == NO_REQ_INSTANCE) |-> !transfer_request)
		else $error("request raised on the non-requesting instance");

	// With transfers disabled no request follows
	chk_request_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		!transfer_request_enable |=> !transfer_request)
		else $error("request raised while transfers disabled");

	// Requests only with the enable set and never on instance two
	chk_request_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		transfer_request |-> ($past(transfer_request_enable) && $past(conv_done)
			&& INSTANCE != NO_REQ_INSTANCE))
		else $error("transfer request without cause");

	// One single-cycle request per finished conversion
	chk_request_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(conv_done && transfer_request_enable && INSTANCE != NO_REQ_INSTANCE)
		|=> transfer_request ##1 !transfer_request)
		else $error("missing or stretched transfer request");
endmodule
`default_nettype wire

// ### verif/converter_control_second_tb_top.sv
`default_nettype none
module converter_control_second_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import conv_ctrl_pkg::*;
	logic                  pclk, presetn, psel, penable, pwrite;
	logic [ADDR_WIDTH-1:0] paddr;
	logic [31:0]           pwdata, prdata, rdv;
	logic                  pready, pslverr, errv, conv_t, cal_t, trim_t;
	logic                  pwr, rep, cal, trim, start, req, req2;
	int                    fails, cmp_count, starts, reqs, reqs2;

	// First converter, and the second one that must never request
	converter_control_second #(.INSTANCE(1)) i_converter_control_second (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_done_toggle(conv_t), .cal_done_toggle(cal_t), .trim_done_toggle(trim_t),
		.converter_power_start(pwr), .repeat_conversion_select(rep), .calibration_run(cal),
		.trim_store_clear(trim), .conversion_start(start), .transfer_request(req));
	converter_control_second #(.INSTANCE(2)) i_converter_control_second_b (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(), .pready(), .pslverr(), .conv_done_toggle(conv_t),
		.cal_done_toggle(cal_t), .trim_done_toggle(trim_t), .converter_power_start(),
		.repeat_conversion_select(), .calibration_run(), .trim_store_clear(),
		.conversion_start(), .transfer_request(req2));

	// Clock
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	// Pulse counters
	always @(posedge pclk)
	begin
		if (start === 1'h1) starts <= starts + 1;
		if (req === 1'h1) reqs <= reqs + 1;
		if (req2 === 1'h1) reqs2 <= reqs2 + 1;
	end

	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
		begin
			n++;
			if (n > 20)
			begin
				fails++;
				finish_test();
			end
			@(posedge pclk);
		end
		// Answer is taken at the same edge that samples pready high
		rdv = prdata;
		errv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [31:0] d);
		apb(1'h1, CTRL_OFFSET, d);
		repeat (3) @(posedge pclk);
	endtask

	// Read back and compare the level outputs too
	task automatic rd_chk(input logic [31:0] exp);
		apb(1'h0, CTRL_OFFSET, 32'h0);
		chk("ctrl", exp, rdv);
		chk("ctrl err", 32'h0, {31'h0, errv});
		chk("levels", {28'h0, exp[3:0]}, {28'h0, trim, cal, rep, pwr});
	endtask

	// Analog completion events
	task automatic ev(input int which);
		case (which)
			0: conv_t <= ~conv_t;
			1: cal_t <= ~cal_t;
			default: trim_t <= ~trim_t;
		endcase
		repeat (10) @(posedge pclk);
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, conv_t, cal_t, trim_t} = 7'h0;
		paddr = '0;
		pwdata = 32'h0;
		{fails, cmp_count, starts, reqs, reqs2} = {5{32'h0}};
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		rd_chk(CTRL_RESET);
		apb(1'h0, 12'h00C, 32'hFFFF_FFFF);
		chk("unmapped err", 32'h1, {31'h0, errv});
		chk("unmapped data", 32'h0, rdv);
		apb(1'h1, 12'h00C, 32'h0000_0001);
		chk("unmapped wr err", 32'h1, {31'h0, errv});
		rd_chk(CTRL_RESET);
		chk("starts", 32'h0, starts);
		wr(32'h0000_0001);
		chk("starts", 32'h1, starts);
		wr(32'h0000_0001);
		chk("starts", 32'h2, starts);
		wr(32'h0000_0003);
		chk("starts", 32'h2, starts);
		rd_chk(32'h0000_0003);
		ev(0);
		chk("starts", 32'h3, starts);
		chk("reqs", 32'h0, reqs);
		wr(32'h0000_0103);
		chk("starts", 32'h3, starts);
		ev(0);
		chk("reqs", 32'h1, reqs);
		chk("starts", 32'h4, starts);
		wr(32'h0000_0101);
		ev(0);
		chk("starts", 32'h4, starts);
		chk("reqs", 32'h2, reqs);
		chk("reqs2", 32'h0, reqs2);
		wr(32'h0000_0105);
		rd_chk(32'h0000_0105);
		ev(1);
		rd_chk(32'h0000_0101);
		wr(32'h0000_0109);
		rd_chk(32'h0000_0109);
		ev(2);
		rd_chk(32'h0000_0101);
		wr(32'h0000_0105);
		wr(32'h0000_0101);
		rd_chk(32'h0000_0105);
		wr(32'h0000_0000);
		rd_chk(32'h0000_0000);
		ev(0);
		chk("reqs", 32'h2, reqs);
		chk("starts", 32'h4, starts);
		finish_test();
	end
endmodule
`default_nettype wire
